// *** core/pwg_pkg.sv ***
// package: address map, field positions and access codes for the protected register write gate
package pwg_pkg;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] DEVCFG_LO_ADDR = 22'h000880;
    localparam logic [ADDR_W-1:0] DEVCFG_HI_ADDR = 22'h000881;
    localparam logic [ADDR_W-1:0] BLK_START_ADDR = 22'h000884;
    localparam logic [ADDR_W-1:0] BLK_RANGE_ADDR = 22'h000885;
    localparam logic [ADDR_W-1:0] VECT_FIRST_ADDR = 22'h000D00;
    localparam logic [ADDR_W-1:0] VECT_LAST_ADDR = 22'h000DFE;
    localparam logic [ADDR_W-1:0] PLL_STS_ADDR = 22'h007011;
    localparam logic [ADDR_W-1:0] HS_PRESCALE_ADDR = 22'h00701A;
    localparam logic [ADDR_W-1:0] LS_PRESCALE_ADDR = 22'h00701B;
    localparam logic [ADDR_W-1:0] CLK_EN0_ADDR = 22'h00701C;
    localparam logic [ADDR_W-1:0] CLK_EN1_ADDR = 22'h00701D;
    localparam logic [ADDR_W-1:0] LOW_PWR_ADDR = 22'h00701E;
    localparam logic [ADDR_W-1:0] CLK_EN3_ADDR = 22'h007020;
    localparam logic [ADDR_W-1:0] PLL_CTL_ADDR = 22'h007021;
    localparam logic [ADDR_W-1:0] SYS_CTL_ADDR = 22'h007022;
    localparam logic [ADDR_W-1:0] WD_COUNT_ADDR = 22'h007023;
    localparam logic [ADDR_W-1:0] WD_KEY_ADDR = 22'h007025;
    localparam logic [ADDR_W-1:0] WD_CTL_ADDR = 22'h007029;
    localparam logic [ADDR_W-1:0] MAP_CONFIG_ADDR = 22'h00702E;
    localparam logic [ADDR_W-1:0] MAP_CONFIG_HI_ADDR = 22'h00702F;
    localparam int UNLOCK_BIT = 6;
    localparam int PWM_MAP_BIT = 0;
    localparam logic MAP_RESET = 1'b1;
    typedef enum logic [1:0] {
        PWG_OP_NONE = 2'b00,
        PWG_OP_UNLOCK = 2'b01,
        PWG_OP_RELOCK = 2'b10
    } pwg_op_t;
endpackage

// *** core/pwg_gate_if.sv ***
// interface: gated write request between the gate and the map register file
`timescale 1ns/1ps
interface pwg_gate_if;
    import pwg_pkg::*;
    logic wrEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic [DATA_W-1:0] rdData;
    modport gate (output wrEn, output addr, output wrData, input rdData);
    modport regs (input wrEn, input addr, input wrData, output rdData);
endinterface

// *** core/pwg_map_regs.sv ***
// module: the mapping configuration register behind the gate
`timescale 1ns/1ps
module pwg_map_regs (
    input wire logic coreClk,
    input wire logic nrst,
    pwg_gate_if.regs bus,
    output logic pwmMapSelect
);
    import pwg_pkg::*;
    logic mapBit_reg;
    logic [DATA_W-1:0] rdData_reg;

    always_ff @(posedge coreClk) begin
        if (!nrst) begin
            mapBit_reg <= MAP_RESET;
        end else if (bus.wrEn && bus.addr == MAP_CONFIG_ADDR) begin
            mapBit_reg <= bus.wrData[PWM_MAP_BIT];
        end
    end

    always_ff @(posedge coreClk) begin
        if (!nrst) begin
            rdData_reg <= '0;
        end else begin
            rdData_reg <= '0;
            if (bus.addr == MAP_CONFIG_ADDR) begin
                rdData_reg[PWM_MAP_BIT] <= mapBit_reg;
            end
        end
    end

    assign bus.rdData = rdData_reg;
    assign pwmMapSelect = mapBit_reg;
endmodule // pwg_map_regs

// *** core/pwg_write_gate.sv ***
// module: write gate that filters processor writes to protected registers
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - with unlock flag clear, processor writes to protected addresses are dropped
// - debug reads and writes always pass; processor reads pass unless a debug access takes the path
// - debug path writes ignore the unlock flag entirely
// - reset clears the unlock flag so protection starts active
// - unlock instruction sets the flag; protected writes then pass
// - relock instruction clears the flag; software relocks after updates
// - flag lives in status register one and is sampled per write
// - device configuration pair, block protect start and range are protected
// - whole vector table 0x0D00 to 0x0DFF, upper word of last entry 0x0DFE included, is protected
// - clock, low power, system control and watchdog words are protected
// - map_config at 0x702E: bit 0 pwm map select, reset 1
module pwg_write_gate (
    input wire logic core_clk,
    input wire logic nrst,
    input wire pwg_pkg::pwg_op_t cpuOp,
    input wire logic cpuWrEn,
    input wire logic cpuRdEn,
    input wire logic [pwg_pkg::ADDR_W-1:0] cpuAddr,
    input wire logic [pwg_pkg::DATA_W-1:0] cpuWrData,
    input wire logic dbgWrEn,
    input wire logic dbgRdEn,
    input wire logic [pwg_pkg::ADDR_W-1:0] dbgAddr,
    input wire logic [pwg_pkg::DATA_W-1:0] dbgWrData,
    output logic [15:0] statusRegOne,
    output logic sysWrEn,
    output logic sysRdEn,
    output logic [pwg_pkg::ADDR_W-1:0] sysAddr,
    output logic [pwg_pkg::DATA_W-1:0] sysWrData,
    output logic [pwg_pkg::DATA_W-1:0] mapRdData,
    output logic pwmMapSelect,
    output logic wrDropped
);
    import pwg_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    function automatic logic isProtected(input logic [ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        if (a == DEVCFG_LO_ADDR || a == DEVCFG_HI_ADDR) hit = 1'b1;
        if (a == BLK_START_ADDR || a == BLK_RANGE_ADDR) hit = 1'b1;
        // last entry is two words wide, so its upper word is covered too
        if (a >= VECT_FIRST_ADDR && a <= VECT_LAST_ADDR + 22'h1) hit = 1'b1;
        case (a)
            PLL_STS_ADDR, HS_PRESCALE_ADDR, LS_PRESCALE_ADDR, CLK_EN0_ADDR,
            CLK_EN1_ADDR, LOW_PWR_ADDR, CLK_EN3_ADDR, PLL_CTL_ADDR,
            SYS_CTL_ADDR, WD_COUNT_ADDR, WD_KEY_ADDR, WD_CTL_ADDR: hit = 1'b1;
            default: ;
        endcase
        return hit;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    logic unlock_reg;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            unlock_reg <= 1'b0;
        end else begin
            case (cpuOp)
                PWG_OP_UNLOCK: unlock_reg <= 1'b1;
                PWG_OP_RELOCK: unlock_reg <= 1'b0;
                default: unlock_reg <= unlock_reg;
            endcase
        end
    end

    always_comb begin
        statusRegOne = '0;
        statusRegOne[UNLOCK_BIT] = unlock_reg;
    end

    //////////////////////////////////////////////////////////////////////////
    // debug master wins the shared path when both request in one cycle
    logic dbgSel;
    logic cpuWrPass;
    assign dbgSel = dbgWrEn | dbgRdEn;
    // flag sampled at the write itself, no ordering with a same-cycle instruction
    assign cpuWrPass = cpuWrEn & (unlock_reg | ~isProtected(cpuAddr));

    always_comb begin
        if (dbgSel) begin
            sysWrEn = dbgWrEn;
            sysRdEn = dbgRdEn;
            sysAddr = dbgAddr;
            sysWrData = dbgWrData;
        end else begin
            sysWrEn = cpuWrPass;
            sysRdEn = cpuRdEn;
            sysAddr = cpuAddr;
            sysWrData = cpuWrData;
        end
    end

    assign wrDropped = ~dbgSel & cpuWrEn & ~cpuWrPass;

    //////////////////////////////////////////////////////////////////////////
    pwg_gate_if gateBus ();
    assign gateBus.wrEn = sysWrEn;
    assign gateBus.addr = sysAddr;
    assign gateBus.wrData = sysWrData;
    assign mapRdData = gateBus.rdData;

    pwg_map_regs mapRegs (
        .coreClk(core_clk),
        .nrst(nrst),
        .bus(gateBus),
        .pwmMapSelect(pwmMapSelect)
    );

    //////////////////////////////////////////////////////////////////////////
    property p_reset_locks;
        @(posedge core_clk) !nrst |=> !statusRegOne[UNLOCK_BIT];
    endproperty
    a_reset_locks: assert property (p_reset_locks) else $error("flag set after reset");

    property p_locked_drop;
        @(posedge core_clk) disable iff (!nrst)
        (!unlock_reg && !dbgSel && cpuWrEn && isProtected(cpuAddr)) |-> !sysWrEn && wrDropped;
    endproperty
    a_locked_drop: assert property (p_locked_drop) else $error("locked write passed");

    property p_unlock_sets;
        @(posedge core_clk) disable iff (!nrst)
        cpuOp == PWG_OP_UNLOCK |=> statusRegOne[UNLOCK_BIT];
    endproperty
    a_unlock_sets: assert property (p_unlock_sets) else $error("unlock failed");

    property p_relock_clears;
        @(posedge core_clk) disable iff (!nrst)
        cpuOp == PWG_OP_RELOCK |=> !statusRegOne[UNLOCK_BIT];
    endproperty
    a_relock_clears: assert property (p_relock_clears) else $error("relock failed");

    property p_dbg_write;
        @(posedge core_clk) disable iff (!nrst)
        dbgWrEn |-> sysWrEn && sysAddr == dbgAddr;
    endproperty
    a_dbg_write: assert property (p_dbg_write) else $error("debug write blocked");

    property p_reads_pass;
        @(posedge core_clk) disable iff (!nrst)
        (cpuRdEn || dbgRdEn) |-> sysRdEn;
    endproperty
    a_reads_pass: assert property (p_reads_pass) else $error("read blocked");

    property p_open_write;
        @(posedge core_clk) disable iff (!nrst)
        (!dbgSel && cpuWrEn && !isProtected(cpuAddr)) |-> sysWrEn && !wrDropped;
    endproperty
    a_open_write: assert property (p_open_write) else $error("open write lost");

    property p_unlocked_write;
        @(posedge core_clk) disable iff (!nrst)
        (unlock_reg && !dbgSel && cpuWrEn) |-> sysWrEn;
    endproperty
    a_unlocked_write: assert property (p_unlocked_write) else $error("unlocked write lost");

    property p_vect_top;
        @(posedge core_clk) disable iff (!nrst)
        (!unlock_reg && !dbgSel && cpuWrEn && cpuAddr == VECT_LAST_ADDR) |-> !sysWrEn;
    endproperty
    a_vect_top: assert property (p_vect_top) else $error("vector entry writable");

    property p_map_write;
        @(posedge core_clk) disable iff (!nrst)
        (sysWrEn && sysAddr == MAP_CONFIG_ADDR) |=> pwmMapSelect == $past(sysWrData[PWM_MAP_BIT]);
    endproperty
    a_map_write: assert property (p_map_write) else $error("map bit not stored");

    property p_map_reset;
        @(posedge core_clk) !nrst |=> pwmMapSelect;
    endproperty
    a_map_reset: assert property (p_map_reset) else $error("map bit reset wrong");

    c_dropped: cover property (@(posedge core_clk) disable iff (!nrst) wrDropped);
    c_unlock_write: cover property (@(posedge core_clk) disable iff (!nrst)
        unlock_reg && cpuWrEn && isProtected(cpuAddr));
    c_dbg_locked: cover property (@(posedge core_clk) disable iff (!nrst)
        !unlock_reg && dbgWrEn && isProtected(dbgAddr));
    c_relock: cover property (@(posedge core_clk) disable iff (!nrst)
        unlock_reg ##1 cpuOp == PWG_OP_RELOCK ##1 !unlock_reg);
endmodule // pwg_write_gate

// *** sim/pwg_regspace_model.sv ***
// partner model: register space behind the gate, latching every gated write
`timescale 1ns/1ps
module pwg_regspace_model (
    input wire logic core_clk,
    input wire logic sysWrEn,
    input wire logic [pwg_pkg::ADDR_W-1:0] sysAddr,
    input wire logic [pwg_pkg::DATA_W-1:0] sysWrData
);
    import pwg_pkg::*;
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    always @(posedge core_clk) begin
        if (sysWrEn === 1'b1) begin
            mem[sysAddr] = sysWrData;
        end
    end
    // never-written words read back as zero
    function automatic logic [DATA_W-1:0] peek(input logic [ADDR_W-1:0] a);
        return mem.exists(a) ? mem[a] : 32'h0;
    endfunction
endmodule // pwg_regspace_model

// *** sim/tb_top.sv ***
// testbench: drives the write gate and checks gating, unlock flag and map register
`timescale 1ns/1ps
module tb_top;
    import pwg_pkg::*;
    logic core_clk, nrst, cpuWrEn, cpuRdEn, dbgWrEn, dbgRdEn, sysWrEn, sysRdEn;
    logic pwmMapSelect, wrDropped;
    pwg_op_t cpuOp;
    logic [ADDR_W-1:0] cpuAddr, dbgAddr, sysAddr;
    logic [DATA_W-1:0] cpuWrData, dbgWrData, sysWrData, mapRdData;
    logic [15:0] statusRegOne;
    int mismatches = 0;
    int compares = 0;
    logic [ADDR_W-1:0] prot [20] = '{DEVCFG_LO_ADDR, DEVCFG_HI_ADDR, BLK_START_ADDR,
        BLK_RANGE_ADDR, VECT_FIRST_ADDR, 22'h000D1A, VECT_LAST_ADDR, 22'h000DFF, PLL_STS_ADDR,
        HS_PRESCALE_ADDR, LS_PRESCALE_ADDR, CLK_EN0_ADDR, CLK_EN1_ADDR, LOW_PWR_ADDR,
        CLK_EN3_ADDR, PLL_CTL_ADDR, SYS_CTL_ADDR, WD_COUNT_ADDR, WD_KEY_ADDR, WD_CTL_ADDR};
    // words just beside the protected set stay writable while locked
    logic [ADDR_W-1:0] openAddr [10] = '{22'h000882, 22'h000883, 22'h000886, 22'h000CFF,
        22'h000E00, 22'h007010, 22'h007012, 22'h00701F, 22'h007024, 22'h00702A};
    pwg_write_gate i_pwg_write_gate (.core_clk(core_clk), .nrst(nrst), .cpuOp(cpuOp),
        .cpuWrEn(cpuWrEn), .cpuRdEn(cpuRdEn), .cpuAddr(cpuAddr), .cpuWrData(cpuWrData),
        .dbgWrEn(dbgWrEn), .dbgRdEn(dbgRdEn), .dbgAddr(dbgAddr), .dbgWrData(dbgWrData),
        .statusRegOne(statusRegOne), .sysWrEn(sysWrEn), .sysRdEn(sysRdEn),
        .sysAddr(sysAddr), .sysWrData(sysWrData), .mapRdData(mapRdData),
        .pwmMapSelect(pwmMapSelect), .wrDropped(wrDropped));
    pwg_regspace_model i_pwg_regspace_model (.core_clk(core_clk), .sysWrEn(sysWrEn),
        .sysAddr(sysAddr), .sysWrData(sysWrData));
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cpu_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                          input logic expWr);
        @(negedge core_clk);
        cpuWrEn = 1'b1;
        cpuAddr = a;
        cpuWrData = d;
        #1 chk(sysWrEn, expWr, "cpu write strobe");
        chk(wrDropped, !expWr, "drop flag");
        @(negedge core_clk);
        cpuWrEn = 1'b0;
    endtask
    task automatic dbg_acc(input logic [ADDR_W-1:0] a, input logic wr);
        @(negedge core_clk);
        {dbgWrEn, dbgRdEn, dbgAddr, dbgWrData} = {wr, !wr, a, 32'h1234_5678};
        #1 chk({sysWrEn, sysRdEn, wrDropped}, {wr, !wr, 1'b0}, "debug access");
        @(negedge core_clk);
        {dbgWrEn, dbgRdEn} = 2'b00;
    endtask
    task automatic op(input pwg_op_t o, input logic [15:0] expSr);
        @(negedge core_clk);
        cpuOp = o;
        @(negedge core_clk);
        cpuOp = PWG_OP_NONE;
        chk(statusRegOne, expSr, "status flag");
    endtask
    task automatic rd_map(input logic [DATA_W-1:0] exp);
        @(negedge core_clk);
        cpuRdEn = 1'b1;
        cpuAddr = MAP_CONFIG_ADDR;
        #1 chk(sysRdEn, 1'b1, "cpu read");
        @(posedge core_clk);
        #1 chk(mapRdData, exp, "map read");
        @(negedge core_clk);
        cpuRdEn = 1'b0;
    endtask
    //////////////////////////////////////////////////////////////////////////////
    task automatic t_locked;
        foreach (prot[i]) begin
            cpu_wr(prot[i], 32'hA5A5_0000 | i, 1'b0);
            chk(i_pwg_regspace_model.peek(prot[i]), 32'h0, "locked");
        end
        // offset lifts every protected word clear of the whole protected set
        foreach (prot[i]) begin
            cpu_wr(prot[i] + 22'h001000, 32'h5A5A_0000 | i, 1'b1);
            chk(i_pwg_regspace_model.peek(prot[i] + 22'h001000), 32'h5A5A_0000 | i, "open");
        end
        foreach (openAddr[i]) begin
            cpu_wr(openAddr[i], 32'h3C3C_0000 | i, 1'b1);
            chk(i_pwg_regspace_model.peek(openAddr[i]), 32'h3C3C_0000 | i, "edge open");
        end
    endtask
    task automatic t_debug;
        dbg_acc(DEVCFG_LO_ADDR, 1'b1);
        chk(i_pwg_regspace_model.peek(DEVCFG_LO_ADDR), 32'h1234_5678, "debug write");
        dbg_acc(WD_CTL_ADDR, 1'b0);
        @(negedge core_clk);
        cpuRdEn = 1'b1;
        cpuAddr = WD_CTL_ADDR;
        #1 chk({sysRdEn, sysAddr}, {1'b1, WD_CTL_ADDR}, "cpu read locked");
        @(negedge core_clk);
        cpuRdEn = 1'b0;
        chk(mapRdData, 32'h0, "other word reads no map bit");
    endtask
    task automatic t_unlock;
        op(PWG_OP_UNLOCK, 16'h0040);
        cpu_wr(WD_CTL_ADDR, 32'h0000_0068, 1'b1);
        op(PWG_OP_RELOCK, 16'h0000);
        cpu_wr(WD_CTL_ADDR, 32'h0000_00FF, 1'b0);
        chk(i_pwg_regspace_model.peek(WD_CTL_ADDR), 32'h0000_0068, "relocked");
        cpu_wr(MAP_CONFIG_ADDR, 32'h0000_0000, 1'b1);
        chk(pwmMapSelect, 1'b0, "map cleared before reset");
        op(PWG_OP_UNLOCK, 16'h0040);
        @(negedge core_clk);
        nrst = 1'b0;
        @(negedge core_clk);
        nrst = 1'b1;
        chk(statusRegOne, 16'h0000, "reset relocks");
        chk(pwmMapSelect, 1'b1, "map after reset");
        cpu_wr(BLK_RANGE_ADDR, 32'h0000_0077, 1'b0);
        chk(i_pwg_regspace_model.peek(BLK_RANGE_ADDR), 32'h0, "locked after reset");
        rd_map(32'h1);
    endtask
    task automatic t_map;
        chk(pwmMapSelect, 1'b1, "map reset");
        rd_map(32'h1);
        cpu_wr(MAP_CONFIG_ADDR, 32'hFFFF_FFFE, 1'b1);
        chk(pwmMapSelect, 1'b0, "map clear");
        rd_map(32'h0);
        cpu_wr(MAP_CONFIG_ADDR, 32'hFFFF_FFFF, 1'b1);
        rd_map(32'h1);
    endtask
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, cpuWrEn, cpuRdEn, dbgWrEn, dbgRdEn} = 5'b0;
        cpuOp = PWG_OP_NONE;
        {cpuAddr, dbgAddr, cpuWrData, dbgWrData} = '0;
        repeat (6) @(negedge core_clk);
        nrst = 1'b1;
        chk(statusRegOne, 16'h0000, "flag after reset");
        t_map();
        t_locked();
        t_debug();
        t_unlock();
        wrap_up();
    end
    initial begin
        #(40 * 3000);
        mismatches++;
        wrap_up();
    end
endmodule // tb_top
